// File: rtl/tpc_clk_sel.sv
// Purpose: Picks write, read and fabric clock sources per TX FIFO
// Assumes: Config and tick pins are asynchronous to clk_i
// Notes: Tick balance monitor flags a nonzero write/read offset while any user write clock is enabled
//
// Behaviour
// - Non-bonded pairs 0/1 and 2/3 write on channel 0 and channel 2 clocks when only pair_ident is set.
// - In x4 bonding all four writes and the fabric use the bonded clock.
// - In x8 bonding all writes and the fabric use the master bonded clock.
// - Automatic selection shares a write clock across blocks only in x8 bonding.
// - An enabled user write clock input overrides automatic selection.
// - Non-bonded reads use the channel's own parallel output clock.
// - x4 bonded reads use this block's bonded core clock.
// - x8 bonded reads use the master block's bonded core clock.
`timescale 1ns/1ps

module tpc_clk_sel (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire tpc_pkg::tpc_cfg_type cfg_i,
    input wire logic wr_tick_i,
    input wire logic rd_tick_i,
    output tpc_pkg::tpc_sel_type [tpc_pkg::NUM_CH-1:0] sel_o,
    output logic offset_err_o
);

    tpc_pkg::tpc_cfg_type cfg_m_q;
    tpc_pkg::tpc_cfg_type cfg_q;
    tpc_pkg::tpc_sel_type [tpc_pkg::NUM_CH-1:0] sel_d;
    tpc_pkg::tpc_sel_type [tpc_pkg::NUM_CH-1:0] sel_q;
    logic [2:0] wr_sync_q;
    logic [2:0] wr_sync_d;
    logic [2:0] rd_sync_q;
    logic [2:0] rd_sync_d;
    logic signed [tpc_pkg::BAL_W-1:0] bal_q;
    logic signed [tpc_pkg::BAL_W-1:0] bal_d;
    logic err_q;
    logic err_d;
    logic wr_edge;
    logic rd_edge;
    logic any_user;

    // Config pins: two-stage synchroniser, second stage feeds logic
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_m_q <= '0;
            cfg_q <= '0;
        end else begin
            cfg_m_q <= cfg_i;
            cfg_q <= cfg_m_q;
        end
    end

    // Per-channel source choice, one copy per channel
    for (genvar ch = 0; ch < tpc_pkg::NUM_CH; ch++) begin : g_ch
        always_comb begin
            sel_d[ch].wr = tpc_pkg::SRC_OWN_PAR_OUT;
            sel_d[ch].rd = tpc_pkg::SRC_OWN_PAR_OUT;
            case (cfg_q.mode)
                tpc_pkg::MODE_X4: begin
                    sel_d[ch].wr = tpc_pkg::SRC_BONDED_CORE;
                    sel_d[ch].rd = tpc_pkg::SRC_BONDED_CORE;
                end
                tpc_pkg::MODE_X8: begin
                    sel_d[ch].wr = tpc_pkg::SRC_MASTER_BONDED_CORE;
                    sel_d[ch].rd = tpc_pkg::SRC_MASTER_BONDED_CORE;
                end
                tpc_pkg::MODE_NONBONDED: begin
                    // Only local own, channel 0 or channel 2 clocks, never another block's
                    if (cfg_q.all_ident) begin
                        sel_d[ch].wr = tpc_pkg::SRC_CH0_PAR_OUT;
                    end else if (cfg_q.pair_ident) begin
                        if (ch < tpc_pkg::PAIR_HI_CH) begin
                            sel_d[ch].wr = tpc_pkg::SRC_CH0_PAR_OUT;
                        end else begin
                            sel_d[ch].wr = tpc_pkg::SRC_CH2_PAR_OUT;
                        end
                    end
                end
                default: begin
                    sel_d[ch].wr = tpc_pkg::SRC_OWN_PAR_OUT;
                    sel_d[ch].rd = tpc_pkg::SRC_OWN_PAR_OUT;
                end
            endcase
            // User input wins over any automatic choice
            if (cfg_q.user_wr[ch]) begin
                sel_d[ch].wr = tpc_pkg::SRC_USER_INPUT;
            end
            // Fabric logic follows the write clock of its channel
            sel_d[ch].fab = sel_d[ch].wr;
        end
    end

    // Selection register, outputs come straight from it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end

    assign sel_o = sel_q;

    // Tick edges: third stage only for edge detection, not stage one
    always_comb begin
        wr_sync_d = {wr_sync_q[1:0], wr_tick_i};
        rd_sync_d = {rd_sync_q[1:0], rd_tick_i};
        wr_edge = wr_sync_q[1] & ~wr_sync_q[2];
        rd_edge = rd_sync_q[1] & ~rd_sync_q[2];
        any_user = |cfg_q.user_wr;
    end

    // Balance of write vs read ticks; drift means a nonzero offset
    always_comb begin
        bal_d = bal_q;
        err_d = err_q;
        if (!any_user) begin
            bal_d = tpc_pkg::BAL_ZERO;
        end else if (wr_edge && !rd_edge) begin
            bal_d = bal_q + tpc_pkg::BAL_ONE;
        end else if (rd_edge && !wr_edge) begin
            bal_d = bal_q - tpc_pkg::BAL_ONE;
        end
        // Sticky until reset: a slip has already corrupted data
        if (bal_q >= tpc_pkg::BAL_LIMIT || bal_q <= -tpc_pkg::BAL_LIMIT) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_sync_q <= '0;
            rd_sync_q <= '0;
            bal_q <= '0;
            err_q <= 1'b0;
        end else begin
            wr_sync_q <= wr_sync_d;
            rd_sync_q <= rd_sync_d;
            bal_q <= bal_d;
            err_q <= err_d;
        end
    end

    assign offset_err_o = err_q;

    // Checks on the selection outputs and the offset flag
    a_pair_lo_write: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (cfg_q.mode == tpc_pkg::MODE_NONBONDED && !cfg_q.all_ident
         && cfg_q.pair_ident && !cfg_q.user_wr[1])
        |=> sel_o[1].wr == tpc_pkg::SRC_CH0_PAR_OUT
    ) else $error("pair low channel not on channel 0 clock");

    a_pair_hi_write: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (cfg_q.mode == tpc_pkg::MODE_NONBONDED && !cfg_q.all_ident
         && cfg_q.pair_ident && !cfg_q.user_wr[3])
        |=> sel_o[3].wr == tpc_pkg::SRC_CH2_PAR_OUT
    ) else $error("pair high channel not on channel 2 clock");

    a_x4_write_fab: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (cfg_q.mode == tpc_pkg::MODE_X4 && !cfg_q.user_wr[2])
        |=> (sel_o[2].wr == tpc_pkg::SRC_BONDED_CORE
             && sel_o[2].fab == sel_o[2].wr)
    ) else $error("x4 write or fabric clock wrong");

    a_x8_write_fab: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (cfg_q.mode == tpc_pkg::MODE_X8 && !cfg_q.user_wr[0])
        |=> (sel_o[0].wr == tpc_pkg::SRC_MASTER_BONDED_CORE
             && sel_o[0].fab == tpc_pkg::SRC_MASTER_BONDED_CORE)
    ) else $error("x8 write or fabric clock wrong");

    a_all_ident_local: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (cfg_q.mode == tpc_pkg::MODE_NONBONDED && cfg_q.all_ident
         && !cfg_q.user_wr[3])
        |=> sel_o[3].wr == tpc_pkg::SRC_CH0_PAR_OUT
    ) else $error("identical channels not on local channel 0 clock");

    a_user_override: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cfg_q.user_wr[1] [*2]
        |=> (sel_o[1].wr == tpc_pkg::SRC_USER_INPUT
             && $past(sel_o[1].wr) == tpc_pkg::SRC_USER_INPUT)
    ) else $error("user write clock not selected");

    a_nb_read_own: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cfg_q.mode == tpc_pkg::MODE_NONBONDED
        |=> sel_o[2].rd == tpc_pkg::SRC_OWN_PAR_OUT
    ) else $error("non-bonded read clock not own");

    a_x4_read: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cfg_q.mode == tpc_pkg::MODE_X4
        |=> sel_o[3].rd == tpc_pkg::SRC_BONDED_CORE
    ) else $error("x4 read clock wrong");

    a_x8_read: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        cfg_q.mode == tpc_pkg::MODE_X8
        |=> sel_o[1].rd == tpc_pkg::SRC_MASTER_BONDED_CORE
    ) else $error("x8 read clock wrong");

    a_offset_flag: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (bal_q >= tpc_pkg::BAL_LIMIT) |=> offset_err_o
    ) else $error("offset error not raised");

    // Read side running fast must be caught as well
    a_offset_neg_flag: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (bal_q <= -tpc_pkg::BAL_LIMIT) |=> offset_err_o
    ) else $error("negative offset error not raised");

    a_err_sticky: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        offset_err_o |=> offset_err_o
    ) else $error("offset error dropped before reset");

    // Without a user clock the balance must not drift into a false flag
    a_idle_balance_zero: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !any_user |=> bal_q == tpc_pkg::BAL_ZERO
    ) else $error("balance moved with no user write clock");

endmodule

// File: rtl/tpc_pkg.sv
// Purpose: Shared types and constants for transmit FIFO clock selection
// Assumes: One transceiver block of four channels per instance
// Notes: Clock sources are encoded selections, not clock nets

package tpc_pkg;

    // Channels in one transceiver block
    localparam int NUM_CH = 4;
    // Channel whose parallel output clock serves the upper pair
    localparam int PAIR_HI_CH = 2;
    // Write/read tick balance counter width and overflow limit
    localparam int BAL_W = 8;
    localparam logic signed [7:0] BAL_LIMIT = 8'sh10;
    localparam logic signed [7:0] BAL_ZERO = 8'sh00;
    localparam logic signed [7:0] BAL_ONE = 8'sh01;

    // Channel arrangement
    typedef enum logic [1:0] {
        MODE_NONBONDED,
        MODE_X4,
        MODE_X8
    } tpc_mode_type;

    // Where a FIFO port takes its clock from
    typedef enum logic [2:0] {
        SRC_OWN_PAR_OUT,
        SRC_CH0_PAR_OUT,
        SRC_CH2_PAR_OUT,
        SRC_BONDED_CORE,
        SRC_MASTER_BONDED_CORE,
        SRC_USER_INPUT
    } tpc_src_type;

    // Static channel configuration seen by the block
    typedef struct packed {
        tpc_mode_type mode;
        logic all_ident;
        logic pair_ident;
        logic [NUM_CH-1:0] user_wr;
    } tpc_cfg_type;

    // Per-channel selection result
    typedef struct packed {
        tpc_src_type wr;
        tpc_src_type rd;
        tpc_src_type fab;
    } tpc_sel_type;

endpackage

// File: dv/tpc_fab_model.sv
// Purpose: Fabric side tick source for the FIFO write or read clock
// Assumes: One tick toggle every four clk_i cycles at the matched rate
// Notes: fast_i doubles the rate to mimic a write or read clock with an offset
`timescale 1ns/1ps

module tpc_fab_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic fast_i,
    output logic tick_o
);
    logic [1:0] cnt_q;

    // Ungated tick as from a pin clock; matched rate keeps zero offset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 2'h0;
            tick_o <= 1'b0;
        end else if (cnt_q >= (fast_i ? 2'h1 : 2'h3)) begin
            cnt_q <= 2'h0;
            tick_o <= ~tick_o; // Slow enough for the 2-flop sync
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule

// File: dv/tx_phase_comp_fifo_clocking_tb_top.sv
// Purpose: Self-checking bench for the TX FIFO clock selection block
// Assumes: Config is static between rows, settles within 4 edges
// Notes: Rows cover every mode; offset monitor tested by hand after
`timescale 1ns/1ps

module tx_phase_comp_fifo_clocking_tb_top;
    localparam tpc_pkg::tpc_src_type OW = tpc_pkg::SRC_OWN_PAR_OUT;
    localparam tpc_pkg::tpc_src_type C0 = tpc_pkg::SRC_CH0_PAR_OUT;
    localparam tpc_pkg::tpc_src_type C2 = tpc_pkg::SRC_CH2_PAR_OUT;
    localparam tpc_pkg::tpc_src_type BC = tpc_pkg::SRC_BONDED_CORE;
    localparam tpc_pkg::tpc_src_type MB = tpc_pkg::SRC_MASTER_BONDED_CORE;
    localparam tpc_pkg::tpc_src_type US = tpc_pkg::SRC_USER_INPUT;
    typedef struct packed {
        tpc_pkg::tpc_cfg_type c;
        tpc_pkg::tpc_src_type [3:0] w;
        tpc_pkg::tpc_src_type r;
    } tpc_row_type;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic fast = 1'b0;
    logic rd_fast = 1'b0;
    tpc_pkg::tpc_cfg_type cfg = '0;
    logic wr_tick;
    logic rd_tick;
    tpc_pkg::tpc_sel_type [tpc_pkg::NUM_CH-1:0] sel;
    logic err;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    tpc_row_type rows [9];

    always #12.5 clk_i = ~clk_i;

    tpc_clk_sel dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_i(cfg),
        .wr_tick_i(wr_tick), .rd_tick_i(rd_tick), .sel_o(sel),
        .offset_err_o(err));
    tpc_fab_model wr_gen_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .fast_i(fast), .tick_o(wr_tick));
    tpc_fab_model rd_gen_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .fast_i(rd_fast), .tick_o(rd_tick));

    task automatic final_report;
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [2:0] e, logic [2:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // Cut a hang short; the run needs well under 1500 cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        // Inputs beside expected wr per channel and rd
        rows[0] = {8'h20, {C0, C0, C0, C0}, OW};
        rows[1] = {8'h10, {C2, C2, C0, C0}, OW};
        rows[2] = {8'h00, {OW, OW, OW, OW}, OW};
        rows[3] = {8'h40, {BC, BC, BC, BC}, BC};
        rows[4] = {8'h80, {MB, MB, MB, MB}, MB};
        rows[5] = {8'h1a, {US, C2, US, C0}, OW};
        rows[6] = {8'h41, {BC, BC, BC, US}, BC};
        rows[7] = {8'hc0, {OW, OW, OW, OW}, OW};
        rows[8] = {8'h30, {C0, C0, C0, C0}, OW};
        repeat (11) @(posedge clk_i);
        #1;
        for (int ch = 0; ch < 4; ch++) begin
            chk("rst_wr", OW, sel[ch].wr);
            chk("rst_rd", OW, sel[ch].rd);
        end
        chk("rst_err", 3'h0, {2'h0, err});
        @(posedge clk_i);
        nrst_i <= 1'b1;
        // Table of configurations; fab must follow wr
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_i);
            cfg <= rows[i].c;
            repeat (4) @(posedge clk_i);
            #1;
            for (int ch = 0; ch < 4; ch++) begin
                chk("wr", rows[i].w[ch], sel[ch].wr);
                chk("rd", rows[i].r, sel[ch].rd);
                chk("fab", rows[i].w[ch], sel[ch].fab);
            end
        end
        // Offset ignored while no user write clock is enabled, and matched rates raise no flag
        @(posedge clk_i);
        cfg <= 8'h00;
        fast <= 1'b1;
        repeat (300) @(posedge clk_i);
        #1;
        chk("err_off", 3'h0, {2'h0, err});
        @(posedge clk_i);
        cfg <= 8'h0f;
        fast <= 1'b0;
        repeat (300) @(posedge clk_i);
        #1;
        chk("err_match", 3'h0, {2'h0, err});
        // Write clock runs fast: slip must be flagged and stick
        @(posedge clk_i);
        fast <= 1'b1;
        for (int k = 0; k < 400 && err !== 1'b1; k++) @(posedge clk_i);
        #1;
        chk("err_slip", 3'h1, {2'h0, err});
        @(posedge clk_i);
        fast <= 1'b0;
        repeat (50) @(posedge clk_i);
        #1;
        chk("err_stick", 3'h1, {2'h0, err});
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("err_rst", 3'h0, {2'h0, err});
        chk("rst2_wr", OW, sel[1].wr);
        // Read clock runs fast after release: negative slip flagged
        @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_fast <= 1'b1;
        for (int k = 0; k < 400 && err !== 1'b1; k++) @(posedge clk_i);
        #1;
        chk("err_rd_slip", 3'h1, {2'h0, err});
        final_report();
    end
endmodule
